/* File: src/fpg_df_gate.sv */
// Dflash sector protection decode and program/erase gate
`timescale 1ns/1ps
`default_nettype none
module fpg_df_gate
    import fpg_pkg::*;
#(
    parameter int SECTORS = FPG_DF_SECT,
    parameter int DPS_W   = FPG_DPS_W,
    parameter int SEC_W   = FPG_SEC_W
) (
    // Protection state
    input  wire logic               open_i,
    input  wire logic [DPS_W-1:0]   size_i,
    input  wire logic               ready_i,
    // Operation request
    input  wire logic               req_i,
    input  wire logic [SEC_W-1:0]   sector_i,
    // Verdict
    output logic [SECTORS-1:0]      mask_o,
    output logic                    grant_o,
    output logic                    deny_o
);

    genvar s;
    generate
        for (s = 0; s < SECTORS; s++) begin : g_sect
            // Sectors 0..size are protected unless open
            assign mask_o[s] = !open_i && (s <= int'(size_i)); // [R6]
        end
    endgenerate

    // Nothing is granted until the reset load has settled
    assign deny_o  = req_i && (mask_o[sector_i] || !ready_i); // [R9]
    assign grant_o = req_i && !deny_o;

endmodule
`default_nettype wire

/* File: src/fpg_pkg.sv */
// Constants, types and register map of the flash protection guard
// Functional notes
// [R1] Only stronger pflash protection; bad writes dropped
// [R2] Pflash register reads return active scenario
// [R3] Only listed scenario transitions are accepted
// [R4] Dflash size changes only when increased
// [R5] Dflash open bit may only go 1-to-0
// [R6] Open bit set means no sector protected
// [R7] Reset loads dflash protection from config byte
// [R8] Software unprotects pflash before reprogramming byte
// [R9] Program/erase to protected dflash sector refused
// [R10] Dflash protection register at offset 0x0009
// [R11] Double-bit fault on load gives maximum protection
package fpg_pkg;

    localparam int          FPG_DATA_W   = 32;
    localparam int          FPG_ADDR_W   = 12;
    localparam int          FPG_DPS_W    = 4;
    localparam int          FPG_DF_SECT  = 16;
    localparam int          FPG_SEC_W    = 4;
    localparam int          FPG_CFG_AW   = 18;

    // Register indices; byte address is four times the index
    localparam logic [11:0] FPG_IDX_PF_PROT = 12'h008;
    localparam logic [11:0] FPG_IDX_DF_PROT = 12'h009;
    localparam logic [11:0] FPG_IDX_STATUS  = 12'h00A;
    localparam logic [11:0] FPG_ADDR_PF_PROT = {FPG_IDX_PF_PROT[9:0], 2'b00};
    localparam logic [11:0] FPG_ADDR_DF_PROT = {FPG_IDX_DF_PROT[9:0], 2'b00};
    localparam logic [11:0] FPG_ADDR_STATUS  = {FPG_IDX_STATUS[9:0], 2'b00};

    // Dflash protection register layout
    localparam int          FPG_DF_OPEN_BIT = 7;
    localparam int          FPG_DF_SIZE_LSB = 0;

    // Status register layout
    localparam int          FPG_ST_DONE_BIT  = 0;
    localparam int          FPG_ST_FAULT_BIT = 1;
    localparam int          FPG_ST_PFREF_BIT = 2;
    localparam int          FPG_ST_DFREF_BIT = 3;
    localparam int          FPG_ST_OPREF_BIT = 4;
    localparam int          FPG_ST_CNT_LSB   = 8;
    localparam int          FPG_ST_CNT_W     = 8;

    // Reset values
    localparam logic [2:0]  FPG_PF_SCEN_RST = 3'h7;
    localparam logic [7:0]  FPG_DF_RST      = 8'h0F;
    localparam logic [7:0]  FPG_DF_SAFE     = 8'h0F;

    // Location of the dflash protection byte in the config field
    localparam logic [17:0] FPG_CFG_PROT_ADDR = 18'h3FF0D;

    // Allowed transitions, bit (from*8 + to)
    localparam logic [63:0] FPG_SCEN_ALLOWED = 64'hFF5A_3C18_080C_0A0F;

    typedef enum logic [2:0] {
        FPG_LD_START = 3'b001,
        FPG_LD_FETCH = 3'b010,
        FPG_LD_RUN   = 3'b100
    } fpg_load_t;

endpackage

/* File: src/fpg_scen_check.sv */
// Pflash protection scenario transition checker
`timescale 1ns/1ps
`default_nettype none
module fpg_scen_check
    import fpg_pkg::*;
(
    // Scenarios
    input  wire logic [2:0] cur_i,
    input  wire logic [2:0] req_i,
    // Verdict
    output logic            allowed_o
);

    logic [5:0] idx;

    assign idx       = {cur_i, req_i};
    assign allowed_o = FPG_SCEN_ALLOWED[idx]; // [R3]

endmodule
`default_nettype wire

/* File: src/fpg_top.sv */
// Flash protection guard: APB registers, reset load and protection gate
`timescale 1ns/1ps
`default_nettype none
module fpg_top
    import fpg_pkg::*;
#(
    parameter int SECTORS = FPG_DF_SECT,
    parameter int SEC_W   = FPG_SEC_W
) (
    // Clock and reset
    input  wire logic                  CLK_I,
    input  wire logic                  RST_I,
    // APB slave
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [FPG_ADDR_W-1:0] PADDR_I,
    input  wire logic [FPG_DATA_W-1:0] PWDATA_I,
    input  wire logic [3:0]            PSTRB_I,
    output logic      [FPG_DATA_W-1:0] PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    // Config byte read port
    output logic                       CFG_RD_REQ_O,
    output logic      [FPG_CFG_AW-1:0] CFG_RD_ADDR_O,
    input  wire logic                  CFG_RD_VALID_I,
    input  wire logic [7:0]            CFG_RD_DATA_I,
    input  wire logic                  CFG_RD_DBERR_I,
    // Dflash program/erase gate
    input  wire logic                  DF_OP_REQ_I,
    input  wire logic [SEC_W-1:0]      DF_OP_SECTOR_I,
    output logic                       DF_OP_GRANT_O,
    output logic                       DF_OP_DENY_O,
    output logic      [SECTORS-1:0]    DF_PROT_MASK_O,
    // Protection state
    output logic      [2:0]            PF_SCENARIO_O,
    output logic                       DF_OPEN_O,
    output logic      [FPG_DPS_W-1:0]  DF_SIZE_O,
    output logic                       LOAD_DONE_O
);

    // Load sequencer
    fpg_load_t                   load_reg;
    fpg_load_t                   load_next;
    logic                        fault_reg;

    // Protection registers
    logic [2:0]                  pf_scen_reg;
    logic                        df_open_reg;
    logic [FPG_DPS_W-1:0]        df_size_reg;

    // Sticky status and refusal counter
    logic                        pf_ref_reg;
    logic                        df_ref_reg;
    logic                        op_ref_reg;
    logic [FPG_ST_CNT_W-1:0]     op_cnt_reg;

    // Bus side
    logic [FPG_DATA_W-1:0]       prdata_reg;
    logic [FPG_DATA_W-1:0]       prdata_next;
    logic                        running;
    logic                        access;
    logic                        wr_go;
    logic                        hit_pf;
    logic                        hit_df;
    logic                        hit_st;
    logic                        hit_any;
    logic                        lane0;

    // Write analysis
    logic [2:0]                  wr_scen;
    logic                        scen_ok;
    logic                        wr_open;
    logic [FPG_DPS_W-1:0]        wr_size;
    logic                        pf_wr;
    logic                        df_wr;
    logic                        st_wr;
    logic                        pf_refused;
    logic                        size_grow;
    logic                        open_close;
    logic                        df_refused;

    // Gate
    logic                        gate_grant;
    logic                        gate_deny;

    // Reset load sequence --------------------------------------------

    always_comb begin
        load_next = load_reg;
        case (load_reg)
            FPG_LD_START: begin
                load_next = FPG_LD_FETCH;
            end
            FPG_LD_FETCH: begin
                if (CFG_RD_VALID_I) begin
                    load_next = FPG_LD_RUN;
                end
            end
            FPG_LD_RUN: begin
                load_next = FPG_LD_RUN;
            end
            default: begin
                load_next = FPG_LD_START;
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            load_reg <= FPG_LD_START;
        end else begin
            load_reg <= load_next;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fault_reg <= 1'b0;
        end else if (load_reg == FPG_LD_FETCH && CFG_RD_VALID_I) begin
            fault_reg <= CFG_RD_DBERR_I; // [R11]
        end
    end

    assign running       = (load_reg == FPG_LD_RUN);
    assign CFG_RD_REQ_O  = (load_reg == FPG_LD_FETCH); // [R7]
    assign CFG_RD_ADDR_O = FPG_CFG_PROT_ADDR; // [R7]
    assign LOAD_DONE_O   = running;

    // APB decode -----------------------------------------------------

    // Bus waits while the protection byte is still being fetched
    assign PREADY_O  = running;
    assign access    = PSEL_I && PENABLE_I && running;
    assign hit_pf    = (PADDR_I == FPG_ADDR_PF_PROT);
    assign hit_df    = (PADDR_I == FPG_ADDR_DF_PROT); // [R10]
    assign hit_st    = (PADDR_I == FPG_ADDR_STATUS);
    assign hit_any   = hit_pf || hit_df || hit_st;
    assign PSLVERR_O = PSEL_I && PENABLE_I && running && !hit_any;
    assign lane0     = PSTRB_I[0];
    assign wr_go     = access && PWRITE_I && hit_any && lane0;

    assign pf_wr = wr_go && hit_pf;
    assign df_wr = wr_go && hit_df;
    assign st_wr = wr_go && hit_st;

    // Pflash scenario write ------------------------------------------

    assign wr_scen = PWDATA_I[2:0];

    fpg_scen_check u_scen (
        .cur_i     (pf_scen_reg),
        .req_i     (wr_scen),
        .allowed_o (scen_ok)
    );

    assign pf_refused = pf_wr && !scen_ok; // [R1]

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pf_scen_reg <= FPG_PF_SCEN_RST;
        end else if (pf_wr && scen_ok) begin
            pf_scen_reg <= wr_scen; // [R1] [R3]
        end
    end

    // Dflash protection write ----------------------------------------

    assign wr_open    = PWDATA_I[FPG_DF_OPEN_BIT];
    assign wr_size    = PWDATA_I[FPG_DF_SIZE_LSB +: FPG_DPS_W];
    assign size_grow  = wr_size > df_size_reg; // [R4]
    assign open_close = df_open_reg && !wr_open; // [R5]
    // A write that asks for any weakening is flagged even if part of it lands
    assign df_refused = df_wr && ((wr_size != df_size_reg && !size_grow) ||
                                  (wr_open && !df_open_reg));

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            df_size_reg <= FPG_DF_RST[FPG_DF_SIZE_LSB +: FPG_DPS_W];
        end else if (load_reg == FPG_LD_FETCH && CFG_RD_VALID_I) begin
            if (CFG_RD_DBERR_I) begin
                df_size_reg <= FPG_DF_SAFE[FPG_DF_SIZE_LSB +: FPG_DPS_W]; // [R11]
            end else begin
                df_size_reg <= CFG_RD_DATA_I[FPG_DF_SIZE_LSB +: FPG_DPS_W]; // [R7]
            end
        end else if (df_wr && size_grow) begin
            df_size_reg <= wr_size; // [R4]
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            df_open_reg <= FPG_DF_RST[FPG_DF_OPEN_BIT];
        end else if (load_reg == FPG_LD_FETCH && CFG_RD_VALID_I) begin
            if (CFG_RD_DBERR_I) begin
                df_open_reg <= FPG_DF_SAFE[FPG_DF_OPEN_BIT]; // [R11]
            end else begin
                df_open_reg <= CFG_RD_DATA_I[FPG_DF_OPEN_BIT]; // [R7]
            end
        end else if (df_wr && open_close) begin
            df_open_reg <= 1'b0; // [R5]
        end
    end

    // Program/erase gate ---------------------------------------------

    fpg_df_gate #(
        .SECTORS (SECTORS),
        .DPS_W   (FPG_DPS_W),
        .SEC_W   (SEC_W)
    ) u_gate (
        .open_i   (df_open_reg),
        .size_i   (df_size_reg),
        .ready_i  (running),
        .req_i    (DF_OP_REQ_I),
        .sector_i (DF_OP_SECTOR_I),
        .mask_o   (DF_PROT_MASK_O),
        .grant_o  (gate_grant),
        .deny_o   (gate_deny)
    );

    assign DF_OP_GRANT_O = gate_grant;
    assign DF_OP_DENY_O  = gate_deny; // [R9]

    // Sticky refusal flags, write one to clear; a new event beats the clear

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pf_ref_reg <= 1'b0;
        end else if (pf_refused) begin
            pf_ref_reg <= 1'b1;
        end else if (st_wr && PWDATA_I[FPG_ST_PFREF_BIT]) begin
            pf_ref_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            df_ref_reg <= 1'b0;
        end else if (df_refused) begin
            df_ref_reg <= 1'b1;
        end else if (st_wr && PWDATA_I[FPG_ST_DFREF_BIT]) begin
            df_ref_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            op_ref_reg <= 1'b0;
        end else if (gate_deny) begin
            op_ref_reg <= 1'b1;
        end else if (st_wr && PWDATA_I[FPG_ST_OPREF_BIT]) begin
            op_ref_reg <= 1'b0;
        end
    end

    // Saturating so a stuck requester cannot wrap the count back to zero
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            op_cnt_reg <= '0;
        end else if (gate_deny && op_cnt_reg != '1) begin
            op_cnt_reg <= op_cnt_reg + 1'b1;
        end
    end

    // Read data ------------------------------------------------------

    always_comb begin
        prdata_next = '0;
        if (hit_pf) begin
            prdata_next[2:0] = pf_scen_reg; // [R2]
        end else if (hit_df) begin
            prdata_next[FPG_DF_OPEN_BIT]                 = df_open_reg;
            prdata_next[FPG_DF_SIZE_LSB +: FPG_DPS_W]    = df_size_reg;
        end else if (hit_st) begin
            prdata_next[FPG_ST_DONE_BIT]                 = running;
            prdata_next[FPG_ST_FAULT_BIT]                = fault_reg;
            prdata_next[FPG_ST_PFREF_BIT]                = pf_ref_reg;
            prdata_next[FPG_ST_DFREF_BIT]                = df_ref_reg;
            prdata_next[FPG_ST_OPREF_BIT]                = op_ref_reg;
            prdata_next[FPG_ST_CNT_LSB +: FPG_ST_CNT_W]  = op_cnt_reg;
        end
    end

    // Refreshed each selected read cycle except the completing access cycle, so the access phase sees current state
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            prdata_reg <= '0;
        end else if (PSEL_I && !PWRITE_I && !(PENABLE_I && running)) begin
            prdata_reg <= prdata_next;
        end
    end

    assign PRDATA_O = prdata_reg;

    // Protection state outputs ---------------------------------------

    assign PF_SCENARIO_O = pf_scen_reg;
    assign DF_OPEN_O     = df_open_reg;
    assign DF_SIZE_O     = df_size_reg;

endmodule
`default_nettype wire

/* File: verif/fpg_chk.sv */
// Assertion checker for the flash protection guard
`timescale 1ns/1ps
`default_nettype none
module fpg_chk
    import fpg_pkg::*;
#(
    parameter int SEC_W = FPG_SEC_W
) (
    // Clock, reset and bus
    input wire logic             CLK_I,
    input wire logic             RST_I,
    input wire logic             PSEL_I,
    input wire logic             PENABLE_I,
    input wire logic             PWRITE_I,
    input wire logic [11:0]      PADDR_I,
    input wire logic [31:0]      PWDATA_I,
    input wire logic [3:0]       PSTRB_I,
    input wire logic             PREADY_O,
    // Config fetch
    input wire logic             CFG_RD_REQ_O,
    input wire logic [17:0]      CFG_RD_ADDR_O,
    input wire logic             CFG_RD_VALID_I,
    input wire logic [7:0]       CFG_RD_DATA_I,
    input wire logic             CFG_RD_DBERR_I,
    // Gate and state
    input wire logic             DF_OP_REQ_I,
    input wire logic [SEC_W-1:0] DF_OP_SECTOR_I,
    input wire logic             DF_OP_GRANT_O,
    input wire logic             DF_OP_DENY_O,
    input wire logic [2:0]       PF_SCENARIO_O,
    input wire logic             DF_OPEN_O,
    input wire logic [3:0]       DF_SIZE_O,
    input wire logic             LOAD_DONE_O
);
    // Own copy of the move table, bit from*8+to, so a slip in the package shows
    localparam logic [63:0] OK_MOVE = 64'hFF5A_3C18_080C_0A0F;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_load; CFG_RD_REQ_O && CFG_RD_VALID_I; endsequence
    sequence s_pf_wr;
        PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] && PADDR_I == FPG_ADDR_PF_PROT;
    endsequence
    sequence s_df_wr;
        PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] && PADDR_I == FPG_ADDR_DF_PROT;
    endsequence
    property p_ready; PREADY_O == LOAD_DONE_O; endproperty
    a_ready: assert property (p_ready) else $error("ready differs from done");
    property p_cfg_addr; CFG_RD_REQ_O |-> CFG_RD_ADDR_O == 18'h3FF0D; endproperty
    a_cfg_addr: assert property (p_cfg_addr) else $error("bad fetch address");
    property p_load_ok;
        s_load ##0 !CFG_RD_DBERR_I |=> LOAD_DONE_O && !CFG_RD_REQ_O
            && DF_OPEN_O == $past(CFG_RD_DATA_I[7]) && DF_SIZE_O == $past(CFG_RD_DATA_I[3:0]);
    endproperty
    a_load_ok: assert property (p_load_ok) else $error("bad load");
    property p_load_bad; s_load ##0 CFG_RD_DBERR_I |=> !DF_OPEN_O && DF_SIZE_O == 4'hF; endproperty
    a_load_bad: assert property (p_load_bad) else $error("bad fault load");
    property p_pf_bad;
        s_pf_wr ##0 !OK_MOVE[{PF_SCENARIO_O, PWDATA_I[2:0]}] |=> $stable(PF_SCENARIO_O);
    endproperty
    a_pf_bad: assert property (p_pf_bad) else $error("illegal move taken");
    property p_pf_good;
        s_pf_wr ##0 OK_MOVE[{PF_SCENARIO_O, PWDATA_I[2:0]}] |=> PF_SCENARIO_O == $past(PWDATA_I[2:0]);
    endproperty
    a_pf_good: assert property (p_pf_good) else $error("legal move lost");
    property p_size_wr;
        s_df_wr ##0 PWDATA_I[3:0] > DF_SIZE_O |=> DF_SIZE_O == $past(PWDATA_I[3:0]);
    endproperty
    a_size_wr: assert property (p_size_wr) else $error("size raise lost");
    property p_size_up; $past(LOAD_DONE_O) |-> DF_SIZE_O >= $past(DF_SIZE_O); endproperty
    a_size_up: assert property (p_size_up) else $error("size dropped");
    property p_open_dn; $past(LOAD_DONE_O) && !$past(DF_OPEN_O) |-> !DF_OPEN_O; endproperty
    a_open_dn: assert property (p_open_dn) else $error("open bit set again");
    property p_deny;
        DF_OP_REQ_I && LOAD_DONE_O |-> DF_OP_DENY_O == (!DF_OPEN_O && DF_OP_SECTOR_I <= DF_SIZE_O)
            && DF_OP_GRANT_O == !DF_OP_DENY_O;
    endproperty
    a_deny: assert property (p_deny) else $error("bad gate verdict");
endmodule
bind fpg_top fpg_chk #(.SEC_W(SEC_W)) u_fpg_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .PREADY_O(PREADY_O), .CFG_RD_REQ_O(CFG_RD_REQ_O), .CFG_RD_ADDR_O(CFG_RD_ADDR_O),
    .CFG_RD_VALID_I(CFG_RD_VALID_I), .CFG_RD_DATA_I(CFG_RD_DATA_I),
    .CFG_RD_DBERR_I(CFG_RD_DBERR_I), .DF_OP_REQ_I(DF_OP_REQ_I),
    .DF_OP_SECTOR_I(DF_OP_SECTOR_I), .DF_OP_GRANT_O(DF_OP_GRANT_O),
    .DF_OP_DENY_O(DF_OP_DENY_O), .PF_SCENARIO_O(PF_SCENARIO_O), .DF_OPEN_O(DF_OPEN_O),
    .DF_SIZE_O(DF_SIZE_O), .LOAD_DONE_O(LOAD_DONE_O)
);
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the flash protection guard
`timescale 1ns/1ps
`default_nettype none
module tb
    import fpg_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, vld = 1'b0, dbe = 1'b0, opreq = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF, sector = 4'h0, dsize;
    logic [7:0]  cfg_d = 8'h00;
    logic [15:0] mask;
    logic [17:0] cfg_addr;
    logic [2:0]  scen;
    logic        pready, pslverr, cfg_req, grant, deny, dopen, done, er;
    int          n_fail = 0, check_count = 0;
    always #2.5 clk_i = ~clk_i;
    fpg_top u_fpg_top (
        .CLK_I(clk_i), .RST_I(rst_i), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CFG_RD_REQ_O(cfg_req),
        .CFG_RD_ADDR_O(cfg_addr), .CFG_RD_VALID_I(vld), .CFG_RD_DATA_I(cfg_d),
        .CFG_RD_DBERR_I(dbe), .DF_OP_REQ_I(opreq), .DF_OP_SECTOR_I(sector),
        .DF_OP_GRANT_O(grant), .DF_OP_DENY_O(deny), .DF_PROT_MASK_O(mask),
        .PF_SCENARIO_O(scen), .DF_OPEN_O(dopen), .DF_SIZE_O(dsize), .LOAD_DONE_O(done)
    );
    task automatic conclude();
        if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait on ready; a hang counts as a failure
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 200);
        if (pready !== 1'b1) begin
            n_fail++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        // Idle cycle so a following call never re-drives psel in this time step
        @(posedge clk_i);
    endtask
    task automatic boot(input logic [7:0] c, input logic e);
        int n;
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(32'({scen, dopen, dsize, pready, deny}), 32'({3'h7, 1'b0, 4'hF, 1'b0, 1'b1}));
        rst_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (cfg_req !== 1'b1 && n < 50);
        if (cfg_req !== 1'b1) begin
            n_fail++;
            conclude();
        end
        chk(32'(cfg_addr), 32'h3FF0D);
        cfg_d <= c; // A new protection byte only reaches the guard through a reset load
        dbe <= e;
        vld <= 1'b1;
        @(posedge clk_i);
        vld <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic t_load();
        boot(8'h83, 1'b0);
        apb(1'b0, FPG_ADDR_DF_PROT, 32'h0);
        chk(rd, 32'h83);
        chk(32'({mask, grant, deny}), 32'({16'h0, 2'b10}));
        boot(8'h80, 1'b1);
        apb(1'b0, FPG_ADDR_DF_PROT, 32'h0);
        chk(rd, 32'h0F);
        chk(32'(mask), 32'hFFFF);
        apb(1'b0, FPG_ADDR_STATUS, 32'h0);
        chk(32'(rd[4:0]), 32'h13);
    endtask
    task automatic t_dps();
        boot(8'h85, 1'b0);
        apb(1'b1, FPG_ADDR_DF_PROT, 32'h03);
        apb(1'b0, FPG_ADDR_DF_PROT, 32'h0);
        chk(rd, 32'h05);
        apb(1'b1, FPG_ADDR_DF_PROT, 32'h85);
        apb(1'b0, FPG_ADDR_DF_PROT, 32'h0);
        chk(rd, 32'h05);
        apb(1'b1, FPG_ADDR_DF_PROT, 32'h07);
        apb(1'b0, FPG_ADDR_DF_PROT, 32'h0);
        chk(rd, 32'h07);
        sector <= 4'h7;
        @(posedge clk_i);
        chk(32'({mask, grant, deny}), 32'({16'h00FF, 2'b01}));
        sector <= 4'h8;
        @(posedge clk_i);
        chk(32'({grant, deny}), 32'h2);
    endtask
    // Only reset reaches scenario 7, so each pair needs its own boot
    task automatic t_scen();
        logic [7:0]  ok [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
        logic [31:0] exp;
        for (int f = 0; f < 8; f++) begin
            for (int t = 0; t < 8; t++) begin
                boot(8'h80, 1'b0);
                apb(1'b1, FPG_ADDR_PF_PROT, 32'(f));
                apb(1'b1, FPG_ADDR_PF_PROT, 32'(t));
                apb(1'b0, FPG_ADDR_PF_PROT, 32'h0);
                exp = ok[f][t] ? 32'(t) : 32'(f);
                chk(rd, exp);
                chk(32'(scen), exp);
                apb(1'b0, FPG_ADDR_STATUS, 32'h0);
                chk(32'(rd[2]), 32'(!ok[f][t]));
            end
        end
    endtask
    task automatic t_bus();
        apb(1'b0, 12'h030, 32'h0);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, FPG_ADDR_STATUS, 32'h0);
        chk(32'({done, rd[0]}), 32'h3);
        chk(32'(rd[4:1]), 32'hC);
        apb(1'b1, FPG_ADDR_STATUS, 32'h18);
        apb(1'b0, FPG_ADDR_STATUS, 32'h0);
        chk(32'(rd[4:0]), 32'h01);
        // A deny in the clearing cycle must win over the clear
        sector <= 4'h0;
        apb(1'b1, FPG_ADDR_STATUS, 32'h10);
        apb(1'b0, FPG_ADDR_STATUS, 32'h0);
        chk(32'(rd[4]), 32'h1);
        pstrb <= 4'hE;
        apb(1'b1, FPG_ADDR_DF_PROT, 32'h0F);
        pstrb <= 4'hF;
        apb(1'b0, FPG_ADDR_DF_PROT, 32'h0);
        chk(rd, 32'h07);
    endtask
    initial begin
        t_load();
        t_dps();
        t_bus();
        t_scen();
        conclude();
    end
endmodule
`default_nettype wire
